// ===== rtl/rtc_cmd_pkg.sv
// Package for the room temperature command-value stage: register map,
// field layout, reset values, timing constants and the output carrier.
// Assumes a 200 MHz system clock and an APB master with 32-bit data.
package rtc_cmd_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int unsigned CLK_HZ          = 200_000_000;
    localparam int unsigned MS_PER_S        = 1000;
    localparam int unsigned CYCLES_PER_MS   = CLK_HZ / MS_PER_S;
    localparam int unsigned EVAL_PERIOD_S   = 30;
    localparam int unsigned EVAL_PERIOD_MS  = EVAL_PERIOD_S * MS_PER_S;
    localparam int unsigned NUM_CH          = 4;

    // ****************************************************************
    // Register map (byte addresses)
    // ****************************************************************
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_SETPT  = 8'h04;
    localparam logic [7:0] ADDR_ACTUAL = 8'h08;
    localparam logic [7:0] ADDR_LEVELW = 8'h0C;
    localparam logic [7:0] ADDR_GAIN   = 8'h10;
    localparam logic [7:0] ADDR_THRESH = 8'h14;
    localparam logic [7:0] ADDR_CYCLE  = 8'h18;
    localparam logic [7:0] ADDR_HYST   = 8'h1C;
    localparam logic [7:0] ADDR_VALUES = 8'h20;

    // Control register fields.
    localparam int unsigned CTRL_HEAT_BIT = 0;
    localparam int unsigned CTRL_ALG_LSB  = 1;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [31:0] RST_CTRL   = 32'h0000_0001;
    localparam logic [15:0] RST_SETPT  = 16'h00D2;
    localparam logic [15:0] RST_ACTUAL = 16'h00D2;
    localparam logic [15:0] RST_LEVELW = 16'h0014;
    localparam logic [15:0] RST_GAIN   = 16'h0220;
    localparam logic [7:0]  RST_THRESH = 8'h03;
    localparam logic [15:0] RST_CYCLE  = 16'h0384;
    localparam logic [15:0] RST_HYST   = 16'h0005;

    localparam logic [6:0]  DUTY_MAX   = 7'd100;
    localparam int unsigned GAIN_SHIFT = 4;

    typedef enum logic [1:0] {
        ALG_CONT_PI = 2'b00,
        ALG_PWM_PI  = 2'b01,
        ALG_TWO_PT  = 2'b10
    } alg_e;

    typedef struct packed {
        logic       byte_send;
        logic [7:0] byte_val;
        logic       bit_send;
        logic       bit_val;
        logic       stat_send;
        logic [7:0] stat_val;
    } cmd_out_s;

endpackage : rtc_cmd_pkg

// ===== rtl/rtc_cmd_out.sv
// Command-value stage of a room temperature controller with an APB slave.
// Assumes synchronous inputs, one 200 MHz clock and an APB master that
// holds each request until pready is seen high.
// Reset is asynchronous and active high; every output is registered.
//
// Overview of operation
// - Command value follows setpoint minus actual temperature (actual minus setpoint for cooling) through chosen algorithm.
// - Each channel selects continuous PI, switching PI with PWM, or two-point.
// - Four independent channels: heat basic, heat extra, cool basic, cool extra.
// - Heating and cooling use separate outputs, one-bit or one-byte per type.
// - Continuous PI recomputes the command value every 30 seconds.
// - Continuous byte is sent only after moving by the set threshold; the code also sends a single zero from an idle mode, whatever the threshold.
// - Switching PI turns the 30-second value into PWM on a bit output.
// - Duty changes only at period end; threshold ignored in switching mode.
// - Each period boundary adopts the latest value computed in that period.
// - At 0 % or 100 % a constant telegram still goes out each period.
// - Switching PI publishes its internal byte only at each period end.
// - All PWM outputs share one common cycle time.
// - Extra level works like basic level with setpoint offset by level width.
// - Power is varied by the on to off ratio within each period.
// - Change-over bit one means heating, zero means cooling; selects active outputs.
//
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/100ps
module rtc_cmd_out
    import rtc_cmd_pkg::*;
#(
    parameter int unsigned CYC_PER_MS = CYCLES_PER_MS,
    parameter int unsigned EVAL_MS    = EVAL_PERIOD_MS
)
(
    input  wire logic                  clk,
    input  wire logic                  reset,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic                       pready,
    output logic [31:0]                prdata,
    output logic                       pslverr,
    output cmd_out_s [NUM_CH-1:0]      chan_out
);

    // ****************************************************************
    // Register file
    // ****************************************************************
    logic [31:0] ctrl_q;
    logic [15:0] setpt_q;
    logic [15:0] actual_q;
    logic [15:0] levelw_q;
    logic [15:0] gain_q;
    logic [15:0] cycle_q;
    logic [15:0] hyst_q;
    logic [7:0]  thresh_q;
    logic        pready_q;
    logic        pslverr_q;
    logic [31:0] prdata_q;
    // Latest computed value per channel, also readable through the value register.
    logic [6:0]  calc_q [NUM_CH];

    wire acc_w  = psel & penable & ~pready_q;
    // A write lands at the edge that ends the access cycle in which pready is high.
    wire wr_en  = psel & penable & pready_q & pwrite;
    wire hit_ct = paddr == ADDR_CTRL;
    wire hit_sp = paddr == ADDR_SETPT;
    wire hit_ac = paddr == ADDR_ACTUAL;
    wire hit_lw = paddr == ADDR_LEVELW;
    wire hit_gn = paddr == ADDR_GAIN;
    wire hit_th = paddr == ADDR_THRESH;
    wire hit_cy = paddr == ADDR_CYCLE;
    wire hit_hy = paddr == ADDR_HYST;
    wire hit_vl = paddr == ADDR_VALUES;
    // Unmapped offsets read as zero and raise the error response.
    wire mapped = hit_ct | hit_sp | hit_ac | hit_lw | hit_gn |
                  hit_th | hit_cy | hit_hy | hit_vl;
    wire [31:0] values_w = {1'b0, calc_q[3], 1'b0, calc_q[2], 1'b0, calc_q[1], 1'b0, calc_q[0]};
    wire [31:0] rd_mux =
        hit_ct ? ctrl_q :
        hit_sp ? {16'h0000, setpt_q} :
        hit_ac ? {16'h0000, actual_q} :
        hit_lw ? {16'h0000, levelw_q} :
        hit_gn ? {16'h0000, gain_q} :
        hit_th ? {24'h0000_00, thresh_q} :
        hit_cy ? {16'h0000, cycle_q} :
        hit_hy ? {16'h0000, hyst_q} :
        hit_vl ? values_w :
        32'h0000_0000;

    // One wait state: pready rises in the second access cycle.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end
        else
        begin
            pready_q  <= acc_w;
            pslverr_q <= acc_w & ~mapped;
            prdata_q  <= (acc_w & ~pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            ctrl_q   <= RST_CTRL;
            setpt_q  <= RST_SETPT;
            actual_q <= RST_ACTUAL;
            levelw_q <= RST_LEVELW;
            gain_q   <= RST_GAIN;
            thresh_q <= RST_THRESH;
            cycle_q  <= RST_CYCLE;
            hyst_q   <= RST_HYST;
        end
        else if (wr_en)
        begin
            if (hit_ct) ctrl_q   <= {23'h00_0000, pwdata[8:0]};
            if (hit_sp) setpt_q  <= pwdata[15:0];
            if (hit_ac) actual_q <= pwdata[15:0];
            if (hit_lw) levelw_q <= pwdata[15:0];
            if (hit_gn) gain_q   <= pwdata[15:0];
            if (hit_th) thresh_q <= pwdata[7:0];
            // A cycle time of zero would give an empty period, so it is stored as one second.
            if (hit_cy) cycle_q  <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
            if (hit_hy) hyst_q   <= pwdata[15:0];
        end
    end

    // ****************************************************************
    // Bus response outputs
    // ****************************************************************
    assign pready  = pready_q;
    assign prdata  = prdata_q;
    assign pslverr = pslverr_q;

    // ****************************************************************
    // Time base: millisecond enable, evaluation tick, shared PWM period
    // ****************************************************************
    logic [31:0] pre_q;
    logic [31:0] eval_q;
    // Position inside the running PWM period and its latched length, in milliseconds.
    logic [26:0] pos_q;
    logic [26:0] period_q;
    logic        ms_q;
    logic        tick_q;

    wire ms_w      = pre_q == CYC_PER_MS - 1;
    wire [26:0] period_w = 27'(cycle_q * MS_PER_S);
    wire per_end   = ms_q & (pos_q >= period_q - 27'd1);
    wire [26:0] pos_nxt = per_end ? 27'd0 : pos_q + 27'd1;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            pre_q    <= 32'h0000_0000;
            eval_q   <= 32'h0000_0000;
            ms_q     <= 1'b0;
            tick_q   <= 1'b0;
            pos_q    <= 27'd0;
            // Until the cycle register is first latched the period lasts one second.
            period_q <= 27'(MS_PER_S);
        end
        else
        begin
            pre_q  <= ms_w ? 32'h0000_0000 : pre_q + 32'h0000_0001;
            ms_q   <= ms_w;
            // The tick comes in the same cycle as the millisecond strobe that closes the interval.
            tick_q <= ms_w & (eval_q == EVAL_MS - 1);
            if (ms_w)
                eval_q <= (eval_q == EVAL_MS - 1) ? 32'h0000_0000 : eval_q + 32'h0000_0001;
            if (ms_q)
                pos_q <= pos_nxt;
            // The period length is only taken at a boundary so a running period never stretches.
            if (per_end)
                period_q <= period_w;
        end
    end

    // ****************************************************************
    // Channels: 0 heat basic, 1 heat extra, 2 cool basic, 3 cool extra
    // ****************************************************************
    wire heat_mode = ctrl_q[CTRL_HEAT_BIT];
    // Gains are unsigned bytes; the zero sign bit keeps the products signed.
    wire signed [8:0] kp_s = {1'b0, gain_q[7:0]};
    wire signed [8:0] ki_s = {1'b0, gain_q[15:8]};
    localparam logic signed [27:0] IMAX = 28'(DUTY_MAX) <<< GAIN_SHIFT;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++)
        begin : g_ch
            // Per-channel integrator and last sent value; the time base is shared.
            localparam bit IS_COOL = gi >= 2;
            localparam bit IS_ADD  = (gi % 2) == 1;
            logic signed [27:0] integ_q;
            logic [6:0]         sent_q;
            logic [6:0]         duty_q;
            logic               tp_q;
            cmd_out_s           out_q;

            wire alg_e  alg    = alg_e'(ctrl_q[CTRL_ALG_LSB + 2*gi +: 2]);
            wire        active = heat_mode ^ IS_COOL;
            wire signed [17:0] off  = IS_ADD ? 18'(signed'(levelw_q)) : 18'sd0;
            wire signed [17:0] sp_c = IS_COOL ? 18'(signed'(setpt_q)) + off
                                              : 18'(signed'(setpt_q)) - off;
            wire signed [17:0] act  = 18'(signed'(actual_q));
            wire signed [17:0] err  = IS_COOL ? act - sp_c : sp_c - act;
            // Gains carry a scale of sixteen; the integrator is clamped to full scale
            // so that a long error never winds it beyond what the output can show.
            wire signed [27:0] p_t  = 28'(kp_s * err);
            wire signed [27:0] i_s  = integ_q + 28'(ki_s * err);
            wire signed [27:0] i_c  = (i_s < 0) ? 28'sd0 : (i_s > IMAX) ? IMAX : i_s;
            wire signed [27:0] y_s  = (p_t + i_c) >>> GAIN_SHIFT;
            wire [6:0] y  = (y_s < 0) ? 7'd0 : (y_s > 28'(DUTY_MAX)) ? DUTY_MAX : y_s[6:0];
            wire [6:0] dl = (y > sent_q) ? y - sent_q : sent_q - y;
            wire big_move = ({1'b0, dl} >= thresh_q) & (y != sent_q);
            // Two-point band: on at or above the hysteresis, off at or below its negative.
            wire tp_on    = err >= 18'(signed'(hyst_q));
            wire tp_off   = err <= -18'(signed'(hyst_q));
            wire tp_nxt   = tp_on ? 1'b1 : tp_off ? 1'b0 : tp_q;
            // Duty used from the next millisecond on; a fresh value only at a boundary.
            wire [6:0]  duty_n = per_end ? calc_q[gi] : duty_q;
            // Position and duty are compared as fractions of the period, with no divider.
            wire [33:0] lhs = 34'(pos_nxt) * 34'd100;
            wire [33:0] rhs = 34'(duty_n) * 34'(period_q);
            wire pwm_on     = lhs < rhs;

            always_ff @(posedge clk or posedge reset)
            begin
                if (reset)
                begin
                    integ_q    <= 28'sd0;
                    calc_q[gi] <= 7'd0;
                    sent_q     <= 7'd0;
                    duty_q     <= 7'd0;
                    tp_q       <= 1'b0;
                    out_q      <= '0;
                end
                else
                begin
                    out_q.byte_send <= 1'b0;
                    out_q.bit_send  <= 1'b0;
                    out_q.stat_send <= 1'b0;
                    if (tick_q)
                    begin
                        // An idle mode winds its integrator down so a change-over starts clean.
                        integ_q    <= active ? i_c : 28'sd0;
                        calc_q[gi] <= active ? y : 7'd0;
                        tp_q       <= active & tp_nxt;
                    end
                    case (alg)
                        ALG_CONT_PI:
                        begin
                            // An idle mode sends a single zero so that its actuator closes.
                            if (tick_q & (active ? big_move : sent_q != 7'd0))
                            begin
                                sent_q          <= active ? y : 7'd0;
                                out_q.byte_val  <= {1'b0, active ? y : 7'd0};
                                out_q.byte_send <= 1'b1;
                            end
                        end
                        ALG_PWM_PI:
                        begin
                            // The boundary telegram goes out at 0 % and 100 % as well.
                            if (per_end)
                            begin
                                duty_q          <= calc_q[gi];
                                out_q.stat_val  <= {1'b0, calc_q[gi]};
                                out_q.stat_send <= 1'b1;
                            end
                            // Between boundaries a telegram marks only a change of level.
                            if (ms_q)
                            begin
                                out_q.bit_val  <= pwm_on;
                                out_q.bit_send <= per_end | (pwm_on != out_q.bit_val);
                            end
                        end
                        ALG_TWO_PT:
                        begin
                            if (tick_q & ((active & tp_nxt) != out_q.bit_val))
                            begin
                                out_q.bit_val  <= active & tp_nxt;
                                out_q.bit_send <= 1'b1;
                            end
                        end
                        default:
                        begin
                            // A channel switched off parks its output low without a telegram.
                            out_q.bit_val <= 1'b0;
                        end
                    endcase
                end
            end

            assign chan_out[gi] = out_q;
        end
    endgenerate

endmodule : rtc_cmd_out

// ===== tb/rtc_cmd_out_asserts.sv
// Checker for the command-value stage: bus handshake and channel telegrams.
// Assumes it is bound to rtc_cmd_out and sees only that module's ports.
`timescale 1ns/100ps
module rtc_cmd_out_asserts
    import rtc_cmd_pkg::*;
#(
    parameter int unsigned CYC_PER_MS = CYCLES_PER_MS,
    parameter int unsigned EVAL_MS    = EVAL_PERIOD_MS
)
(
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire cmd_out_s [NUM_CH-1:0] chan_out
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    // Mirror of the mode bit, so that inactive channels can be recognised.
    logic heat_q;
    wire  ctrl_wr = psel && penable && pready && pwrite && (paddr == ADDR_CTRL);
    always_ff @(posedge clk or posedge reset)
        if (reset)
            heat_q <= RST_CTRL[CTRL_HEAT_BIT];
        else if (ctrl_wr)
            heat_q <= pwdata[CTRL_HEAT_BIT];
    ready_wait_a: assert property (psel && $rose(penable) |=> pready)
        else $error("pready missing in second access cycle");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    err_ready_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
        else $error("error response malformed");
    for (genvar i = 0; i < NUM_CH; i++)
    begin : g_ch
        stat_bit_a: assert property (chan_out[i].stat_send |-> chan_out[i].bit_send)
            else $error("status value sent without switching telegram");
        period_start_a: assert property (chan_out[i].stat_send |->
            chan_out[i].bit_val == (chan_out[i].stat_val != 8'h00))
            else $error("period does not open with its duty phase");
        bit_change_a: assert property ($changed(chan_out[i].bit_val) |-> chan_out[i].bit_send)
            else $error("switching output changed without telegram");
        byte_gap_a: assert property (chan_out[i].byte_send |=> !chan_out[i].byte_send [*8])
            else $error("byte telegrams too close together");
        inactive_zero_a: assert property (chan_out[i].byte_send && heat_q != (i < 2) &&
            heat_q == $past(heat_q, 3) |-> chan_out[i].byte_val == 8'h00)
            else $error("inactive channel sent a nonzero value");
    end
    cover property (chan_out[1].byte_send);
    cover property (chan_out[0].stat_send && chan_out[0].stat_val == 8'h64);
    cover property (chan_out[2].bit_send && chan_out[2].bit_val);
endmodule : rtc_cmd_out_asserts

bind rtc_cmd_out rtc_cmd_out_asserts #(.CYC_PER_MS(CYC_PER_MS), .EVAL_MS(EVAL_MS)) u_chk (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .chan_out(chan_out));

// ===== tb/electrothermal_valve_drive.sv
// Valve drive model that follows the switching telegrams of one channel.
// Assumes the channel carrier and the bench clock; travel time in cycles.
`timescale 1ns/100ps
module electrothermal_valve_drive
    import rtc_cmd_pkg::*;
#(
    parameter int unsigned TRAVEL = 1000
)
(
    input  wire logic     clk,
    input  wire logic     reset,
    input  wire cmd_out_s cmd,
    output logic          fully_open
);
    logic        on_q;
    int unsigned pos_q;
    // The drive hears only telegrams, never the level between them.
    always_ff @(posedge clk or posedge reset)
        if (reset)
            on_q <= 1'b0;
        else if (cmd.bit_send)
            on_q <= cmd.bit_val;
    // The position integrates on time, so it follows the mean value.
    always_ff @(posedge clk or posedge reset)
        if (reset)
            pos_q <= 0;
        else if (on_q && pos_q < TRAVEL)
            pos_q <= pos_q + 1;
        else if (!on_q && pos_q > 0)
            pos_q <= pos_q - 1;
    assign fully_open = (pos_q == TRAVEL);
endmodule : electrothermal_valve_drive

// ===== tb/testbench.sv
// Bench for the command-value stage: APB driver, output monitor, drive.
// Assumes a 1 ms timebase of 4 clocks and a 5 ms evaluation tick.
`timescale 1ns/100ps
module testbench
    import rtc_cmd_pkg::*;
;
    localparam int PER = 4000;
    logic        clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic        pready, pslverr, fully_open;
    logic [15:0] sp;
    int          bad_count = 0, n_checks = 0, on_cnt = 0;
    logic [32:0] q_apb[$];
    logic [7:0]  q_byte[$], q_stat[$];
    logic        q_bit[$], q_tp[$];
    int          q_on[$];
    cmd_out_s [NUM_CH-1:0] chan_out;
    rtc_cmd_out #(.CYC_PER_MS(4), .EVAL_MS(5)) u_dut (.clk(clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .chan_out(chan_out));
    // Drive travel is a third of the period, so a period at 100 % duty fully sweeps it.
    electrothermal_valve_drive #(.TRAVEL(PER / 3)) u_drive (.clk(clk), .reset(reset),
        .cmd(chan_out[0]), .fully_open(fully_open));
    always #2.5 clk = ~clk;
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        q_apb.push_back(e);
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wait_period;
        for (int i = 0; i < 6 * PER && chan_out[0].stat_send !== 1'b1; i++)
            @(posedge clk);
        @(posedge clk);
    endtask : wait_period
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : complete_run
    always @(posedge clk)
    begin
        if (pready === 1'b1)
            check({pslverr, prdata}, q_apb.pop_front());
        if (chan_out[0].bit_val === 1'b1)
            on_cnt++;
        if (chan_out[0].bit_send === 1'b1)
            check(chan_out[0].bit_val, q_bit.pop_front());
        if (chan_out[0].bit_send === 1'b1 && chan_out[0].bit_val === 1'b0 && on_cnt > 0)
        begin
            check(on_cnt, q_on.pop_front());
            on_cnt = 0;
        end
        if (chan_out[0].stat_send === 1'b1)
            check(chan_out[0].stat_val, q_stat.pop_front());
        if (chan_out[1].byte_send === 1'b1)
            check(chan_out[1].byte_val, q_byte.pop_front());
        if (chan_out[2].bit_send === 1'b1)
            check(chan_out[2].bit_val, q_tp.pop_front());
        if (|{chan_out[0].byte_send, chan_out[1].bit_send, chan_out[1].stat_send,
              chan_out[2].byte_send, chan_out[2].stat_send, chan_out[3]} !== 1'b0)
            check(1'b1, 1'b0);
    end
    initial
    begin
        sp = 16'h0100 + 16'($urandom(32'hd015) % 256);
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        apb(1'b0, ADDR_CTRL, $urandom, {1'b0, RST_CTRL});
        apb(1'b0, 8'h24, $urandom, {1'b1, 32'h0000_0000});
        apb(1'b1, ADDR_GAIN, 0, 0);
        apb(1'b1, ADDR_CYCLE, 0, 0);
        apb(1'b0, ADDR_CYCLE, $urandom, 33'h0_0000_0001);
        // Upper data bits are random; the narrow registers must ignore them.
        apb(1'b1, ADDR_SETPT, {16'($urandom), sp}, 0);
        apb(1'b1, ADDR_ACTUAL, {16'($urandom), sp - 16'h001E}, 0);
        apb(1'b1, ADDR_CTRL, 32'h0000_01C3, 0);
        q_byte.push_back(8'h0A);
        q_stat.push_back(8'h1E);
        q_bit.push_back(1'b1);
        q_bit.push_back(1'b0);
        q_on.push_back(PER * 30 / 100);
        apb(1'b1, ADDR_GAIN, {16'($urandom), 16'h0010}, 0);
        wait_period;
        apb(1'b0, ADDR_VALUES, $urandom, 33'h0_0000_0A1E);
        q_byte.push_back(8'h00);
        for (int k = 0; k < 2; k++)
        begin
            q_stat.push_back(8'h00);
            q_bit.push_back(1'b0);
        end
        apb(1'b1, ADDR_ACTUAL, {16'h0000, sp}, 0);
        wait_period;
        wait_period;
        q_byte.push_back(8'h64);
        for (int k = 0; k < 2; k++)
        begin
            q_stat.push_back(8'h64);
            q_bit.push_back(1'b1);
        end
        q_on.push_back(2 * PER);
        apb(1'b1, ADDR_ACTUAL, {16'h0000, sp - 16'h00C8}, 0);
        wait_period;
        wait_period;
        check(fully_open, 1'b1);
        q_byte.push_back(8'h00);
        q_tp.push_back(1'b1);
        q_stat.push_back(8'h00);
        q_bit.push_back(1'b0);
        apb(1'b1, ADDR_CTRL, 32'h0000_01C2, 0);
        apb(1'b1, ADDR_ACTUAL, {16'h0000, sp + 16'h000A}, 0);
        wait_period;
        repeat (40) @(posedge clk);
        check(q_bit.size() + q_stat.size() + q_byte.size() + q_tp.size() + q_on.size(), 0);
        complete_run;
    end
    initial
    begin
        repeat (8 * PER) @(posedge clk);
        bad_count++;
        complete_run;
    end
endmodule : testbench
